// File: src/dam_pkg.sv
// Shared constants, types and register map of the drive auxiliary monitor.
// Assumes one 200 MHz clock; analog values in 0.01 %, bus voltage in 0.1 %, frequency in 0.01 Hz.
package dam_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS   = 5;
    localparam int BRAKE_STEP_NS   = 1000;
    localparam int BRAKE_STEP_CYC  = (BRAKE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BRAKE_STEPS     = 100;
    localparam int MS_NS           = 1000000;
    localparam int FAN_DELAY_S     = 60;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_ADT_LVLA = 8'h04;
    localparam logic [7:0] ADDR_ADT_HYSA = 8'h08;
    localparam logic [7:0] ADDR_ADT_LVLB = 8'h0C;
    localparam logic [7:0] ADDR_ADT_HYSB = 8'h10;
    localparam logic [7:0] ADDR_BRK_THR  = 8'h14;
    localparam logic [7:0] ADDR_BRK_DUTY = 8'h18;
    localparam logic [7:0] ADDR_OVERMOD  = 8'h1C;
    localparam logic [7:0] ADDR_PWM_FREQ = 8'h20;
    localparam logic [7:0] ADDR_MIN_FREQ = 8'h24;
    localparam logic [7:0] ADDR_LIVE     = 8'h28;
    localparam logic [7:0] ADDR_INT_STAT = 8'h2C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h30;
    // ----------------------------------------
    // Control fields and reset values
    // ----------------------------------------
    localparam int CTRL_CHSEL_BIT  = 0;
    localparam int CTRL_BRKEN_BIT  = 1;
    localparam int CTRL_BELOW_BIT  = 2;
    localparam int CTRL_FAN_LSB    = 3;
    localparam int CTRL_PWMAUTO_BIT = 5;
    localparam logic [15:0] RST_CTRL     = 16'h0008;
    localparam logic [15:0] RST_ADT_LVLA = 16'h07D0;
    localparam logic [15:0] RST_ADT_LVLB = 16'h1388;
    localparam logic [15:0] RST_ADT_HYS  = 16'h01F4;
    localparam logic [15:0] PCT_MAX      = 16'h2710;
    localparam logic [15:0] RST_BRK_THR  = 16'h04E2;
    localparam logic [15:0] BRK_THR_MIN  = 16'h044C;
    localparam logic [15:0] BRK_THR_MAX  = 16'h0578;
    localparam logic [15:0] RST_BRK_DUTY = 16'h0064;
    localparam logic [15:0] BRK_DUTY_MIN = 16'h0014;
    localparam logic [15:0] RST_OVERMOD  = 16'h0069;
    localparam logic [15:0] OVERMOD_MIN  = 16'h0064;
    localparam logic [15:0] OVERMOD_MAX  = 16'h006E;
    localparam logic [15:0] RST_PWM_FREQ = 16'h05DC;
    localparam logic [15:0] FREQ_MAX     = 16'hEA60;
    localparam logic [15:0] RST_MIN_FREQ = 16'h0000;
    localparam logic [7:0]  FAN_ON_TEMP  = 8'h2D;
    localparam logic [7:0]  FAN_OFF_TEMP = 8'h28;
    // ----------------------------------------
    // Interrupt bits
    // ----------------------------------------
    localparam int EVT_ADTA  = 0;
    localparam int EVT_ADTB  = 1;
    localparam int EVT_BRAKE = 2;
    localparam int EVT_FAN   = 3;
    localparam int EVT_SHUT  = 4;
    localparam int EVT_W     = 5;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {FAN_POWERON, FAN_RUN, FAN_THERMAL, FAN_RSVD} dam_fan_e;
    typedef enum logic {BRK_IDLE, BRK_ACTIVE} dam_brk_e;
    typedef struct packed {
        logic        chSel;
        logic        brakeEn;
        logic        belowAct;
        dam_fan_e    fanMode;
        logic        pwmAuto;
        logic [15:0] adtLevelA;
        logic [15:0] adtHystA;
        logic [15:0] adtLevelB;
        logic [15:0] adtHystB;
        logic [15:0] brakeThr;
        logic [15:0] brakeDuty;
        logic [15:0] overmod;
        logic [15:0] pwmFreq;
        logic [15:0] minFreq;
    } dam_cfg_s;
    // Last field is bit 0, so the layout matches the EVT_ bit numbers
    typedef struct packed {
        logic shutdown;
        logic fan;
        logic brake;
        logic adtB;
        logic adtA;
    } dam_stat_s;
endpackage

// File: src/dam_aux_monitor.sv
// Drive auxiliary monitor: analog level detect, brake chopper, low-limit action, fan, overmod, PWM pattern.
// Assumes all inputs synchronous to clk and a one-cycle strobe register port from software.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
// How it works
// - Detector watches one analog channel; selector 0 first input, 1 second, default 0.
// - Two independent detection conditions, own level and hysteresis, same selected channel.
// - Detection output sets when input exceeds level 0-100 %, defaults 20 and 50.
// - Hysteresis acts downward only, limited to its level, default 5 %.
// - Output clears below level minus hysteresis, holds its state in between.
// - With chopper enabled, braking starts when bus voltage exceeds threshold.
// - Braking stops when bus voltage drops below the threshold.
// - Threshold 110.0-140.0 % of nominal bus, default 125.0 %.
// - Brake transistor duty set by rate 20-100 %, 100 means always on.
// - Set frequency below low limit: run at limit (0) or shut down (1).
// - Fan mode 0 runs the fan from power-up.
// - Fan mode 1, default, runs the fan when the drive runs.
// - Fan mode 2 on above 45 C, off below 40 C, else hold.
// - Overmod factor 1.00-1.10, default 1.05, scales the output voltage ceiling.
// - Switchover frequency 0 to max, default 15.00 Hz; selector 0 keeps 7-segment.
// - Selector 1 uses 7-segment below switchover and 5-segment above it.
module dam_aux_monitor import dam_pkg::*; #(
    parameter int MS_CYC       = MS_NS / CLK_PERIOD_NS,
    parameter int FAN_DELAY_MS = FAN_DELAY_S * 1000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    output logic             irq,
    // Process inputs
    input  wire logic [15:0] analogInputFirst,
    input  wire logic [15:0] analogInputSecond,
    input  wire logic [15:0] busVolt,
    input  wire logic [7:0]  heatsinkTemp,
    input  wire logic        driveRunning,
    input  wire logic [15:0] setFreq,
    input  wire logic [15:0] outFreq,
    input  wire logic [15:0] voltNominal,
    // Control and status outputs
    output logic             adtCondA,
    output logic             adtCondB,
    output logic             brakeActive,
    output logic             brakeGate,
    output logic             fanOn,
    output logic             shutdownReq,
    output logic      [15:0] freqCmd,
    output logic      [15:0] voltCeiling,
    output logic             pwmFiveSeg
);
    function automatic logic [15:0] clampRange(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clampRange = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // Hysteresis never below zero: clamp to level before subtracting
    function automatic logic [15:0] lowBound(input logic [15:0] lvl, input logic [15:0] hys);
        lowBound = lvl - ((hys > lvl) ? lvl : hys);
    endfunction
    dam_cfg_s              cfg_q;
    logic      [EVT_W-1:0] intStat_q;
    logic      [EVT_W-1:0] intMask_q;
    logic      [EVT_W-1:0] evt;
    dam_stat_s             live;
    logic      [15:0]      selIn;
    logic      [15:0]      lowA;
    logic      [15:0]      lowB;
    logic                  adtA_q;
    logic                  adtB_q;
    dam_brk_e              brk_q;
    logic      [7:0]       stepDiv_q;
    logic      [6:0]       stepCnt_q;
    logic                  brakeGate_q;
    logic                  fanOn_q;
    logic      [31:0]      msDiv_q;
    logic      [31:0]      fanDelay_q;
    logic                  shut_q;
    logic      [15:0]      freqCmd_q;
    logic      [15:0]      voltCeil_q;
    logic                  pwm5_q;
    logic      [15:0]      rdData_q;
    logic                  msTick;
    logic                  stepTick;
    dam_stat_s             prev_q;
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q.chSel     <= RST_CTRL[CTRL_CHSEL_BIT];
            cfg_q.brakeEn   <= RST_CTRL[CTRL_BRKEN_BIT];
            cfg_q.belowAct  <= RST_CTRL[CTRL_BELOW_BIT];
            cfg_q.fanMode   <= dam_fan_e'(RST_CTRL[CTRL_FAN_LSB +: 2]);
            cfg_q.pwmAuto   <= RST_CTRL[CTRL_PWMAUTO_BIT];
            cfg_q.adtLevelA <= RST_ADT_LVLA;
            cfg_q.adtHystA  <= RST_ADT_HYS;
            cfg_q.adtLevelB <= RST_ADT_LVLB;
            cfg_q.adtHystB  <= RST_ADT_HYS;
            cfg_q.brakeThr  <= RST_BRK_THR;
            cfg_q.brakeDuty <= RST_BRK_DUTY;
            cfg_q.overmod   <= RST_OVERMOD;
            cfg_q.pwmFreq   <= RST_PWM_FREQ;
            cfg_q.minFreq   <= RST_MIN_FREQ;
            intMask_q       <= '0;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) begin
                cfg_q.chSel    <= regWrData[CTRL_CHSEL_BIT];
                cfg_q.brakeEn  <= regWrData[CTRL_BRKEN_BIT];
                cfg_q.belowAct <= regWrData[CTRL_BELOW_BIT];
                // Reserved mode 3 falls back to the default run mode
                cfg_q.fanMode  <= (regWrData[CTRL_FAN_LSB +: 2] == 2'(FAN_RSVD)) ? FAN_RUN
                                  : dam_fan_e'(regWrData[CTRL_FAN_LSB +: 2]);
                cfg_q.pwmAuto  <= regWrData[CTRL_PWMAUTO_BIT];
            end else if (regAddr == ADDR_ADT_LVLA) begin
                cfg_q.adtLevelA <= clampRange(regWrData, '0, PCT_MAX);
            end else if (regAddr == ADDR_ADT_HYSA) begin
                cfg_q.adtHystA <= clampRange(regWrData, '0, PCT_MAX);
            end else if (regAddr == ADDR_ADT_LVLB) begin
                cfg_q.adtLevelB <= clampRange(regWrData, '0, PCT_MAX);
            end else if (regAddr == ADDR_ADT_HYSB) begin
                cfg_q.adtHystB <= clampRange(regWrData, '0, PCT_MAX);
            end else if (regAddr == ADDR_BRK_THR) begin
                cfg_q.brakeThr <= clampRange(regWrData, BRK_THR_MIN, BRK_THR_MAX);
            end else if (regAddr == ADDR_BRK_DUTY) begin
                cfg_q.brakeDuty <= clampRange(regWrData, BRK_DUTY_MIN, RST_BRK_DUTY);
            end else if (regAddr == ADDR_OVERMOD) begin
                cfg_q.overmod <= clampRange(regWrData, OVERMOD_MIN, OVERMOD_MAX);
            end else if (regAddr == ADDR_PWM_FREQ) begin
                cfg_q.pwmFreq <= clampRange(regWrData, '0, FREQ_MAX);
            end else if (regAddr == ADDR_MIN_FREQ) begin
                cfg_q.minFreq <= clampRange(regWrData, '0, FREQ_MAX);
            end else if (regAddr == ADDR_INT_MASK) begin
                intMask_q <= regWrData[EVT_W-1:0];
            end
        end
    end
    // ----------------------------------------
    // Analog level detection
    // ----------------------------------------
    assign selIn = cfg_q.chSel ? analogInputSecond : analogInputFirst;
    assign lowA  = lowBound(cfg_q.adtLevelA, cfg_q.adtHystA);
    assign lowB  = lowBound(cfg_q.adtLevelB, cfg_q.adtHystB);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adtA_q <= 1'b0;
            adtB_q <= 1'b0;
        end else begin
            if (selIn > cfg_q.adtLevelA) begin
                adtA_q <= 1'b1;
            end else if (selIn < lowA) begin
                adtA_q <= 1'b0;
            end
            if (selIn > cfg_q.adtLevelB) begin
                adtB_q <= 1'b1;
            end else if (selIn < lowB) begin
                adtB_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_adt_set;
        (selIn > cfg_q.adtLevelA) |=> adtA_q;
    endproperty
    a_adt_set: assert property (p_adt_set) else $error("cond A did not set above level");
    property p_adt_clr;
        (selIn < lowB) && (selIn <= cfg_q.adtLevelB) |=> !adtB_q;
    endproperty
    a_adt_clr: assert property (p_adt_clr) else $error("cond B did not clear below low bound");
    property p_adt_hold;
        (selIn >= lowA) && (selIn <= cfg_q.adtLevelA) |=> $stable(adtA_q);
    endproperty
    a_adt_hold: assert property (p_adt_hold) else $error("cond A changed inside hysteresis band");
    // ----------------------------------------
    // Brake chopper
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brk_q <= BRK_IDLE;
        end else begin
            case (brk_q)
                BRK_IDLE: begin
                    if (cfg_q.brakeEn && busVolt > cfg_q.brakeThr) begin
                        brk_q <= BRK_ACTIVE;
                    end
                end
                BRK_ACTIVE: begin
                    // Equal to threshold keeps braking to avoid chatter at the edge
                    if (!cfg_q.brakeEn || busVolt < cfg_q.brakeThr) begin
                        brk_q <= BRK_IDLE;
                    end
                end
                default: brk_q <= BRK_IDLE;
            endcase
        end
    end
    // 1 us steps, 100 steps a period: 10 kHz chopping, 1 % duty resolution
    assign stepTick = (stepDiv_q == 8'(BRAKE_STEP_CYC - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stepDiv_q <= '0;
            stepCnt_q <= '0;
        end else if (brk_q == BRK_IDLE) begin
            stepDiv_q <= '0;
            stepCnt_q <= '0;
        end else if (stepTick) begin
            stepDiv_q <= '0;
            stepCnt_q <= (stepCnt_q == 7'(BRAKE_STEPS - 1)) ? '0 : stepCnt_q + 7'd1;
        end else begin
            stepDiv_q <= stepDiv_q + 8'd1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brakeGate_q <= 1'b0;
        end else begin
            brakeGate_q <= (brk_q == BRK_ACTIVE) && ({9'd0, stepCnt_q} < cfg_q.brakeDuty);
        end
    end
    property p_brk_on;
        cfg_q.brakeEn && (busVolt > cfg_q.brakeThr) |=> (brk_q == BRK_ACTIVE);
    endproperty
    a_brk_on: assert property (p_brk_on) else $error("braking did not start above threshold");
    property p_brk_off;
        (busVolt < cfg_q.brakeThr) |=> (brk_q == BRK_IDLE) ##1 !brakeGate_q;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("braking did not stop below threshold");
    property p_brk_full;
        (brk_q == BRK_ACTIVE) && (cfg_q.brakeDuty == RST_BRK_DUTY) |=> brakeGate_q;
    endproperty
    a_brk_full: assert property (p_brk_full) else $error("full duty gate not continuously on");
    // ----------------------------------------
    // Fan control
    // ----------------------------------------
    assign msTick = (msDiv_q == 32'(MS_CYC - 1));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            msDiv_q <= '0;
        end else begin
            msDiv_q <= msTick ? '0 : msDiv_q + 32'd1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fanOn_q    <= 1'b0;
            fanDelay_q <= '0;
        end else begin
            case (cfg_q.fanMode)
                FAN_POWERON: begin
                    fanOn_q    <= 1'b1;
                    fanDelay_q <= '0;
                end
                FAN_THERMAL: begin
                    fanDelay_q <= '0;
                    if (heatsinkTemp > FAN_ON_TEMP) begin
                        fanOn_q <= 1'b1;
                    end else if (heatsinkTemp < FAN_OFF_TEMP) begin
                        fanOn_q <= 1'b0;
                    end
                end
                default: begin
                    if (driveRunning) begin
                        fanOn_q    <= 1'b1;
                        fanDelay_q <= '0;
                    end else if (fanOn_q && msTick) begin
                        if (fanDelay_q == 32'(FAN_DELAY_MS - 1)) begin
                            fanOn_q    <= 1'b0;
                            fanDelay_q <= '0;
                        end else begin
                            fanDelay_q <= fanDelay_q + 32'd1;
                        end
                    end
                end
            endcase
        end
    end
    property p_fan_pwr;
        (cfg_q.fanMode == FAN_POWERON) |=> fanOn_q;
    endproperty
    a_fan_pwr: assert property (p_fan_pwr) else $error("fan off in power-on mode");
    property p_fan_run;
        (cfg_q.fanMode == FAN_RUN) && driveRunning |=> fanOn_q && (fanDelay_q == 0);
    endproperty
    a_fan_run: assert property (p_fan_run) else $error("fan not on while running");
    property p_fan_temp;
        (cfg_q.fanMode == FAN_THERMAL) && (heatsinkTemp < FAN_OFF_TEMP) |=> !fanOn_q;
    endproperty
    a_fan_temp: assert property (p_fan_temp) else $error("fan not off below low temperature");
    // ----------------------------------------
    // Frequency limit, overmod, PWM pattern
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shut_q     <= 1'b0;
            freqCmd_q  <= '0;
            voltCeil_q <= '0;
            pwm5_q     <= 1'b0;
        end else begin
            if (setFreq < cfg_q.minFreq) begin
                shut_q    <= cfg_q.belowAct;
                freqCmd_q <= cfg_q.belowAct ? '0 : cfg_q.minFreq;
            end else begin
                shut_q    <= 1'b0;
                freqCmd_q <= setFreq;
            end
            voltCeil_q <= 16'((32'(voltNominal) * 32'(cfg_q.overmod)) / 32'd100);
            pwm5_q     <= cfg_q.pwmAuto && (outFreq > cfg_q.pwmFreq);
        end
    end
    property p_below;
        (setFreq < cfg_q.minFreq) && !cfg_q.belowAct |=> !shut_q && (freqCmd_q == $past(cfg_q.minFreq));
    endproperty
    a_below: assert property (p_below) else $error("low-limit run did not clamp frequency");
    property p_pwm;
        !cfg_q.pwmAuto || (outFreq <= cfg_q.pwmFreq) |=> !pwm5_q;
    endproperty
    a_pwm: assert property (p_pwm) else $error("5-segment chosen when 7-segment required");
    // ----------------------------------------
    // Status, interrupts, read port and outputs
    // ----------------------------------------
    assign live = '{adtA: adtA_q, adtB: adtB_q, brake: (brk_q == BRK_ACTIVE), fan: fanOn_q, shutdown: shut_q};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= '0;
        end else begin
            prev_q <= live;
        end
    end
    assign evt = live & ~prev_q;
    // A new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intStat_q <= '0;
        end else if (regWr && regAddr == ADDR_INT_STAT) begin
            intStat_q <= (intStat_q & ~regWrData[EVT_W-1:0]) | evt;
        end else begin
            intStat_q <= intStat_q | evt;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= '0;
        end else if (regRd) begin
            if (regAddr == ADDR_CTRL) begin
                rdData_q <= {10'd0, cfg_q.pwmAuto, cfg_q.fanMode, cfg_q.belowAct, cfg_q.brakeEn, cfg_q.chSel};
            end else if (regAddr == ADDR_ADT_LVLA) begin
                rdData_q <= cfg_q.adtLevelA;
            end else if (regAddr == ADDR_ADT_HYSA) begin
                rdData_q <= cfg_q.adtHystA;
            end else if (regAddr == ADDR_ADT_LVLB) begin
                rdData_q <= cfg_q.adtLevelB;
            end else if (regAddr == ADDR_ADT_HYSB) begin
                rdData_q <= cfg_q.adtHystB;
            end else if (regAddr == ADDR_BRK_THR) begin
                rdData_q <= cfg_q.brakeThr;
            end else if (regAddr == ADDR_BRK_DUTY) begin
                rdData_q <= cfg_q.brakeDuty;
            end else if (regAddr == ADDR_OVERMOD) begin
                rdData_q <= cfg_q.overmod;
            end else if (regAddr == ADDR_PWM_FREQ) begin
                rdData_q <= cfg_q.pwmFreq;
            end else if (regAddr == ADDR_MIN_FREQ) begin
                rdData_q <= cfg_q.minFreq;
            end else if (regAddr == ADDR_LIVE) begin
                rdData_q <= {10'd0, pwm5_q, live};
            end else if (regAddr == ADDR_INT_STAT) begin
                rdData_q <= {11'd0, intStat_q};
            end else if (regAddr == ADDR_INT_MASK) begin
                rdData_q <= {11'd0, intMask_q};
            end else begin
                rdData_q <= '0;
            end
        end else begin
            rdData_q <= '0;
        end
    end
    property p_evt;
        $rose(adtA_q) |=> intStat_q[EVT_ADTA] ##1 (intStat_q[EVT_ADTA] || $past(regWr));
    endproperty
    a_evt: assert property (p_evt) else $error("detect rise not latched in status");
    assign regRdData   = rdData_q;
    assign irq         = |(intStat_q & intMask_q);
    assign adtCondA    = adtA_q;
    assign adtCondB    = adtB_q;
    assign brakeActive = (brk_q == BRK_ACTIVE);
    assign brakeGate   = brakeGate_q;
    assign fanOn       = fanOn_q;
    assign shutdownReq = shut_q;
    assign freqCmd     = freqCmd_q;
    assign voltCeiling = voltCeil_q;
    assign pwmFiveSeg  = pwm5_q;
endmodule

// File: verif/testbench.sv
// Self-checking bench for the drive auxiliary monitor.
// Assumes dam_pkg and dam_aux_monitor from src/; the fan delay is shortened by parameters.
`timescale 1ns/1ps
module testbench import dam_pkg::*; ;
    typedef struct {logic [15:0] ain; logic a; logic b;} dam_row_s;
    logic        clk = 0, rstn = 0, regWr = 0, regRd = 0, driveRunning = 0;
    logic [7:0]  regAddr = 0, heatsinkTemp = 8'h19;
    logic [15:0] regWrData = 0, analogInputFirst = 0, analogInputSecond = 0, busVolt = 16'h03E8;
    logic [15:0] setFreq = 16'h01F4, outFreq = 16'h0640, voltNominal = 16'h03E8;
    logic [15:0] regRdData, freqCmd, voltCeiling;
    logic        irq, adtCondA, adtCondB, brakeActive, brakeGate, fanOn, shutdownReq, pwmFiveSeg;
    int          mismatches = 0, compares = 0, n;
    logic [7:0]  temps[3] = '{8'h2E, 8'h2A, 8'h27};
    logic [2:0]  fanExp = 3'b011;
    // Levels 20.00/50.00 %, hysteresis 5.00 %: edges and the hold band of each
    dam_row_s    rows[8] = '{'{16'h07D0, 0, 0}, '{16'h07D1, 1, 0}, '{16'h05DC, 1, 0}, '{16'h05DB, 0, 0},
                             '{16'h1389, 1, 1}, '{16'h1194, 1, 1}, '{16'h1193, 1, 0}, '{16'h0064, 0, 0}};
    dam_aux_monitor #(.MS_CYC(4), .FAN_DELAY_MS(3)) dut (.clk, .rstn, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .irq, .analogInputFirst, .analogInputSecond, .busVolt, .heatsinkTemp, .driveRunning,
        .setFreq, .outFreq, .voltNominal, .adtCondA, .adtCondB, .brakeActive, .brakeGate, .fanOn,
        .shutdownReq, .freqCmd, .voltCeiling, .pwmFiveSeg);
    always #2.5 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, e);
    endtask
    // Sample 1 ns past the edge so the design's updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        wr(ADDR_INT_MASK, 16'h0001);
        foreach (rows[i]) begin
            @(posedge clk) analogInputFirst <= rows[i].ain;
            cyc(3);
            chk(adtCondA, rows[i].a);
            chk(adtCondB, rows[i].b);
        end
        chk(irq, 1'b1);
        wr(ADDR_INT_STAT, 16'h0001);
        cyc(2);
        chk(irq, 1'b0);
        wr(ADDR_CTRL, 16'h0009);
        @(posedge clk) analogInputFirst <= 16'h1770;
        cyc(3);
        chk(adtCondA, 1'b0);
        @(posedge clk) analogInputSecond <= 16'h0834;
        cyc(3);
        chk(adtCondA, 1'b1);
        $display("detect test done");
        // Mid-run reset: the six settings read back must be at their defaults
        @(posedge clk) rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd(ADDR_CTRL, 16'h0008);
        rd(ADDR_ADT_LVLA, 16'h07D0);
        rd(ADDR_BRK_THR, 16'h04E2);
        rd(ADDR_BRK_DUTY, 16'h0064);
        rd(ADDR_OVERMOD, 16'h0069);
        rd(ADDR_PWM_FREQ, 16'h05DC);
        rd(8'h40, 16'h0000);
        $display("reset test done");
        wr(ADDR_OVERMOD, 16'h006E);
        wr(ADDR_MIN_FREQ, 16'h03E8);
        cyc(3);
        chk(voltCeiling, 16'h044C);
        chk(pwmFiveSeg, 1'b0);
        chk(freqCmd, 16'h03E8);
        wr(ADDR_CTRL, 16'h002C);
        cyc(3);
        chk(pwmFiveSeg, 1'b1);
        chk(shutdownReq, 1'b1);
        chk(freqCmd, 16'h0000);
        wr(ADDR_CTRL, 16'h000A);
        @(posedge clk) busVolt <= 16'h04E3;
        cyc(3);
        chk(brakeActive, 1'b1);
        chk(brakeGate, 1'b1);
        wr(ADDR_BRK_DUTY, 16'h0014);
        cyc(200);
        n = 0;
        // Any window of one full chopping period holds the same on-time
        repeat (20000) #5 n += int'(brakeGate);
        chk(16'(n), 16'h0FA0);
        @(posedge clk) busVolt <= 16'h04E1;
        cyc(3);
        chk(brakeActive, 1'b0);
        $display("brake test done");
        wr(ADDR_CTRL, 16'h0010);
        foreach (temps[i]) begin
            @(posedge clk) heatsinkTemp <= temps[i];
            cyc(3);
            chk(fanOn, fanExp[i]);
        end
        wr(ADDR_CTRL, 16'h0008);
        @(posedge clk) driveRunning <= 1'b1;
        cyc(3);
        chk(fanOn, 1'b1);
        @(posedge clk) driveRunning <= 1'b0;
        cyc(8);
        chk(fanOn, 1'b1);
        cyc(16);
        chk(fanOn, 1'b0);
        wr(ADDR_CTRL, 16'h0000);
        cyc(3);
        chk(fanOn, 1'b1);
        $display("fan test done");
        report_and_stop();
    end
    initial begin
        #500_000;
        mismatches++;
        report_and_stop();
    end
endmodule
